// ---- analog_front_model.sv ----
// Behavioural comparator and input multiplexer facing the converter
`timescale 1ns/1ps
module analog_front_model #(
  parameter logic [11:0] LEVEL0 = 12'hA5C,
  parameter logic [11:0] LEVEL1 = 12'h3C7,
  parameter logic [11:0] LEVEL2 = 12'h0B4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Converter side
  input wire logic [2:0] analog_input_sel,
  input wire logic ladder_on,
  input wire logic [11:0] ladder_code,
  output logic comp_above
);
  logic junk_r;
  logic [11:0] level;

  // Toggles while unpowered so a stale compare never passes for data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      junk_r <= 1'b0;
    end else begin
      junk_r <= ~junk_r;
    end
  end

  always_comb begin
    case (analog_input_sel)
      3'h1: level = LEVEL0;
      3'h2: level = LEVEL1;
      3'h4: level = LEVEL2;
      default: level = 12'h000;
    endcase
  end

  assign comp_above = (ladder_on && analog_input_sel != 3'h0) ? (level >= ladder_code) : junk_r;
endmodule : analog_front_model

// ---- conv_timer.sv ----
// Conversion time base: unit prescaler and unit counter
`timescale 1ns/1ps
`include "sar_adc_defines.svh"
module conv_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sequencer side
  conv_timer_if.timer tif
);
  localparam logic [`PRE_W-1:0] PRE_LAST = `PRE_W'(`UNIT_CYCLES - 1);
  localparam logic [`UNITS_W-1:0] ONE = `UNITS_W'(1);

  logic [`PRE_W-1:0] pre_r;
  logic [`UNITS_W-1:0] units_r;
  logic busy_r;

  assign tif.tick = busy_r && (pre_r == PRE_LAST);
  assign tif.expire = tif.tick && (units_r == tif.target - ONE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
    end else if (tif.start) begin
      busy_r <= 1'b1;
    end else if (tif.stop || tif.expire) begin
      busy_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else if (tif.start || tif.tick) begin
      pre_r <= '0;
    end else if (busy_r) begin
      pre_r <= pre_r + `PRE_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      units_r <= '0;
    end else if (tif.start) begin
      units_r <= '0;
    end else if (tif.tick) begin
      units_r <= units_r + ONE;
    end
  end
endmodule : conv_timer

// ---- conv_timer_if.sv ----
// Link between the conversion sequencer and its time base
`timescale 1ns/1ps
`include "sar_adc_defines.svh"
interface conv_timer_if;
  logic start;
  logic stop;
  logic [`UNITS_W-1:0] target;
  logic tick;
  logic expire;
  modport timer (input start, input stop, input target, output tick, output expire);
  modport ctrl (output start, output stop, output target, input tick, input expire);
endinterface : conv_timer_if

// ---- sar_adc_control_unit.sv ----
// Converter control unit: APB registers, conversion sequencer and SAR logic
`timescale 1ns/1ps
`include "sar_adc_defines.svh"
module sar_adc_control_unit (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end
  output logic [2:0] analog_input_sel,
  output logic ladder_on,
  output logic [11:0] ladder_code,
  input wire logic comp_above,
  // Interrupt request
  output logic done_irq
);
  localparam logic [`ADDR_W-1:0] A_CTL = `ADDR_W'({`IDX_CONTROL, 2'b00});
  localparam logic [`ADDR_W-1:0] A_MODE = `ADDR_W'({`IDX_MODE, 2'b00});
  localparam logic [`ADDR_W-1:0] A_LOW = `ADDR_W'({`IDX_RESULT_LOW, 2'b00});
  localparam logic [`ADDR_W-1:0] A_HIGH = `ADDR_W'({`IDX_RESULT_HIGH, 2'b00});

  conv_timer_if tif ();

  sar_adc_pkg::conv_state_t st_r;
  logic [7:0] ctl_r;
  logic [7:0] mode_r;
  logic [7:0] low_r;
  logic [7:0] high_r;
  logic [31:0] prdata_r;
  logic res8_q;
  logic dbl_q;
  logic [2:0] div_q;
  logic first12_r;
  sar_adc_pkg::sar_word_t sar_r;
  sar_adc_pkg::sar_word_t trial_r;
  logic [`UNITS_W-1:0] base_units;

  logic acc;
  logic hit;
  logic wr_ctl;
  logic wr_mode;
  logic wr_low;
  logic wr_high;
  logic start_req;
  logic abort_req;
  logic done_evt;

  // APB decode; zero wait states, unmapped addresses answer with an error
  assign acc = psel && penable;
  assign hit = (paddr == A_CTL) || (paddr == A_MODE) || (paddr == A_LOW) || (paddr == A_HIGH);
  assign pready = acc;
  assign pslverr = acc && !hit;
  assign prdata = prdata_r;
  assign wr_ctl = acc && pwrite && (paddr == A_CTL);
  assign wr_mode = acc && pwrite && (paddr == A_MODE);
  assign wr_low = acc && pwrite && (paddr == A_LOW);
  assign wr_high = acc && pwrite && (paddr == A_HIGH);

  assign start_req = wr_ctl && pwdata[`CTL_RUN] && (st_r == sar_adc_pkg::CONV_IDLE);
  assign abort_req = wr_ctl && !pwdata[`CTL_RUN] && (st_r == sar_adc_pkg::CONV_RUN);
  assign done_evt = (st_r == sar_adc_pkg::CONV_RUN) && tif.expire;

  // Read data captured in the setup phase so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        A_CTL: prdata_r <= {24'h00_0000, ctl_r};
        A_MODE: prdata_r <= {24'h00_0000, mode_r};
        A_LOW: prdata_r <= {24'h00_0000, low_r};
        A_HIGH: prdata_r <= {24'h00_0000, high_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; completion beats a same-cycle write to run and done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= `BYTE_RESET;
    end else begin
      if (wr_ctl) begin
        ctl_r[`CTL_CHAN_HI:`CTL_CHAN_LO+1] <= pwdata[`CTL_CHAN_HI:`CTL_CHAN_LO+1];
        ctl_r[`CTL_CHAN_LO] <= pwdata[`CTL_CHAN_LO];
        ctl_r[`CTL_CHAN_LO-1] <= pwdata[`CTL_CHAN_LO-1];
        ctl_r[`CTL_IRQ_EN] <= pwdata[`CTL_IRQ_EN];
        ctl_r[`CTL_RUN] <= pwdata[`CTL_RUN];
        if (!pwdata[`CTL_DONE]) begin
          ctl_r[`CTL_DONE] <= 1'b0;
        end
      end
      if (done_evt) begin
        ctl_r[`CTL_RUN] <= 1'b0;
        ctl_r[`CTL_DONE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= `BYTE_RESET;
    end else if (wr_mode) begin
      mode_r <= pwdata[7:0];
    end
  end

  // First 12-bit conversion after reset or after an 8-to-12 switch runs doubled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first12_r <= 1'b1;
    end else if (wr_mode && mode_r[`MODE_RES8] && !pwdata[`MODE_RES8]) begin
      first12_r <= 1'b1;
    end else if (done_evt && !res8_q) begin
      first12_r <= 1'b0;
    end
  end

  // Settings held steady for the whole conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res8_q <= 1'b0;
      dbl_q <= 1'b0;
      div_q <= 3'h0;
    end else if (start_req) begin
      res8_q <= mode_r[`MODE_RES8];
      dbl_q <= first12_r && !mode_r[`MODE_RES8];
      div_q <= {low_r[`LOW_DIV_B2], mode_r[`MODE_DIV_HI:`MODE_DIV_LO]};
    end
  end

  // Conversion length in units: steps scaled by the division ratio plus two
  assign base_units = ((res8_q ? `STEPS_8BIT : `STEPS_12BIT) << div_q)
                      + `STEPS_EXTRA;
  assign tif.target = dbl_q ? (base_units << 1) : base_units;
  assign tif.start = start_req;
  assign tif.stop = abort_req;

  conv_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= sar_adc_pkg::CONV_IDLE;
    end else begin
      case (st_r)
        sar_adc_pkg::CONV_IDLE: begin
          if (start_req) begin
            st_r <= sar_adc_pkg::CONV_RUN;
          end
        end
        sar_adc_pkg::CONV_RUN: begin
          if (abort_req || done_evt) begin
            st_r <= sar_adc_pkg::CONV_IDLE;
          end
        end
        default: st_r <= sar_adc_pkg::CONV_IDLE;
      endcase
    end
  end

  // One trial per unit; the ladder has a full unit to settle before sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_r <= 12'h000;
      trial_r <= 12'h000;
    end else if (start_req) begin
      sar_r <= 12'h000;
      trial_r <= mode_r[`MODE_RES8] ? `TRIAL_8BIT : `TRIAL_12BIT;
    end else if (tif.tick && (st_r == sar_adc_pkg::CONV_RUN)) begin
      if (comp_above) begin
        sar_r <= sar_r | trial_r;
      end
      trial_r <= trial_r >> 1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_r <= `BYTE_RESET;
    end else if (done_evt && !res8_q) begin
      low_r[`LOW_DATA_HI:`LOW_DATA_LO] <= sar_r[3:0];
    end else if (wr_low) begin
      low_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_r <= `BYTE_RESET;
    end else if (done_evt) begin
      high_r <= res8_q ? sar_r[7:0] : sar_r[11:4];
    end else if (wr_high) begin
      high_r <= pwdata[7:0];
    end
  end

  // Channel code 0 to 2 is one-hot onto the multiplexer; others select nothing
  always_comb begin
    analog_input_sel = 3'h0;
    case (ctl_r[`CTL_CHAN_HI:`CTL_CHAN_LO])
      4'h0: analog_input_sel = 3'h1;
      4'h1: analog_input_sel = 3'h2;
      4'h2: analog_input_sel = 3'h4;
      default: analog_input_sel = 3'h0;
    endcase
  end

  assign ladder_on = (st_r == sar_adc_pkg::CONV_RUN);
  assign ladder_code = sar_r | trial_r;
  assign done_irq = ctl_r[`CTL_DONE] && ctl_r[`CTL_IRQ_EN];

  // Checks
  logic [17:0] run_cnt_r;
  logic [17:0] exp_cycles;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt_r <= 18'h00000;
    end else if (start_req) begin
      run_cnt_r <= 18'h00001;
    end else if (st_r == sar_adc_pkg::CONV_RUN) begin
      run_cnt_r <= run_cnt_r + 18'h00001;
    end
  end

  assign exp_cycles = 18'(((dbl_q ? 2 : 1) * ((res8_q ? 32 : 52) * (1 << div_q) + 2))
                          * `UNIT_CYCLES);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    wr_ctl && pwdata[`CTL_RUN] && (st_r == sar_adc_pkg::CONV_IDLE);
  endsequence

  sequence s_finish;
    (st_r == sar_adc_pkg::CONV_RUN) && tif.expire;
  endsequence

  a_start_runs_ladder: assert property (
    s_start |=> ctl_r[`CTL_RUN] && ladder_on)
    else $error("start write did not begin a conversion");
  a_finish_flag_run: assert property (
    s_finish |=> ctl_r[`CTL_DONE] && !ctl_r[`CTL_RUN] && !ladder_on)
    else $error("completion did not set done and clear run together");
  a_abort_stops: assert property (
    abort_req |=> !ladder_on ##1 $stable(high_r) [*4])
    else $error("abort did not stop the conversion");
  // Ties the request to the completion, not just to the flag it is built from
  a_irq_follows: assert property (
    s_finish and ctl_r[`CTL_IRQ_EN] && !wr_ctl |=> done_irq)
    else $error("interrupt request missing after completion with enable set");
  a_flag_sticky: assert property (
    ctl_r[`CTL_DONE] && !(wr_ctl && !pwdata[`CTL_DONE]) |=> ctl_r[`CTL_DONE])
    else $error("done flag cleared without a software write");
  a_low_kept_8bit: assert property (
    s_finish and res8_q |=> $stable(low_r) && high_r == $past(sar_r[7:0]))
    else $error("8-bit result placement wrong");
  a_split_12bit: assert property (
    s_finish and !res8_q |=> high_r == $past(sar_r[11:4]) && low_r[7:4] == $past(sar_r[3:0]))
    else $error("12-bit result placement wrong");
  a_conv_length: assert property (
    s_finish |-> run_cnt_r == exp_cycles)
    else $error("conversion length does not match the division ratio");
  a_mux_select: assert property (
    ctl_r[`CTL_CHAN_HI:`CTL_CHAN_LO] == 4'h2 |-> analog_input_sel == 3'h4)
    else $error("channel two not routed");
  a_result_source: assert property ($changed(high_r) |-> $past(done_evt) || $past(wr_high))
    else $error("result byte changed outside completion");
endmodule : sar_adc_control_unit

// ---- sar_adc_defines.svh ----
// Register map, field positions and timing constants of the conversion control unit
// What this block does
// - Channel field, control bits 7..4, codes 0 to 2 route analog inputs 0 to 2.
// - Writing 1 to control bit 2 starts a conversion.
// - At completion the run bit clears in the same cycle the done flag sets.
// - Writing 0 to the run bit aborts; the aborted result is not valid.
// - Reset clears the run bit and stops the converter.
// - Control bit 1 is the done flag, set when a conversion completes.
// - Interrupt request is raised while done flag and enable bit 0 are both 1.
// - Done flag stays set until software clears it by a write.
// - Mode bit 6 selects resolution: 0 for 12 bits, 1 for 8 bits.
// - 8-bit result goes wholly to the high byte; low byte stays unchanged.
// - 12-bit result: upper 8 bits to high byte, lower 4 to low bits 7..4.
// - Division code: result-low bit 0 is MSB, mode bits 1..0 below; ratio 1/2^code.
// - 12-bit conversion lasts (52 / ratio + 2) third-instruction-cycle units.
// - 8-bit conversion lasts (32 / ratio + 2) third-instruction-cycle units.
// - Time doubles for first 12-bit conversion after reset or an 8-to-12 switch.
// - Reference ladder turns on at conversion start and off at its end.
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_CONTROL 16'hFE58
`define IDX_MODE 16'hFE59
`define IDX_RESULT_LOW 16'hFE5A
`define IDX_RESULT_HIGH 16'hFE5B
`define ADDR_W 18
`define BYTE_RESET 8'h00

// Field positions
`define CTL_CHAN_HI 7
`define CTL_CHAN_LO 4
`define CTL_RUN 2
`define CTL_DONE 1
`define CTL_IRQ_EN 0
`define MODE_RES8 6
`define MODE_DIV_HI 1
`define MODE_DIV_LO 0
`define LOW_DIV_B2 0
`define LOW_DATA_HI 7
`define LOW_DATA_LO 4

// Conversion timing in units of one third of an instruction cycle
`define UNIT_TIME_NS 100
`define CLK_PERIOD_NS 10
`define UNIT_CYCLES (`UNIT_TIME_NS / `CLK_PERIOD_NS)
`define STEPS_12BIT 14'h0034
`define STEPS_8BIT 14'h0020
`define STEPS_EXTRA 14'h0002
`define UNITS_W 14
`define PRE_W 4

// Successive approximation start trials
`define TRIAL_12BIT 12'h800
`define TRIAL_8BIT 12'h080

`endif

// ---- sar_adc_pkg.sv ----
// Types shared by the conversion control unit
package sar_adc_pkg;
  typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_t;
  typedef logic [11:0] sar_word_t;
endpackage : sar_adc_pkg

// ---- test_sar_adc_control_unit.sv ----
// Self-checking bench for the conversion control unit
`timescale 1ns/1ps
`include "sar_adc_defines.svh"
module test_sar_adc_control_unit;
  localparam int TIMEOUT_CYCLES = 40000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] analog_input_sel;
  logic ladder_on;
  logic [11:0] ladder_code;
  logic comp_above;
  logic done_irq;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;

  always #5 pclk = ~pclk;

  sar_adc_control_unit i_sar_adc_control_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .analog_input_sel(analog_input_sel),
    .ladder_on(ladder_on), .ladder_code(ladder_code), .comp_above(comp_above),
    .done_irq(done_irq));

  analog_front_model i_analog_front_model (.pclk(pclk), .presetn(presetn),
    .analog_input_sel(analog_input_sel), .ladder_on(ladder_on), .ladder_code(ladder_code),
    .comp_above(comp_above));

  task test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  always @(posedge pclk) begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES) begin
      num_errors++;
      $display("unexpected at %0t: run too long", $time);
      test_done;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // One APB transfer; an idle edge first keeps back-to-back calls race free
  // Waits for pready with no cycle limit of its own; the bench timeout ends a hang
  task apb(input logic wr, input logic [15:0] idx, input logic [7:0] data);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, data};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd_check(input logic [15:0] idx, input logic [7:0] exp, input string what);
    apb(1'b0, idx, 8'h00);
    check(rd, {24'h000000, exp}, what);
  endtask : rd_check

  function automatic int units(input logic res8, input int code, input logic dbl);
    int u;
    u = ((res8 ? 32 : 52) << code) + 2;
    return dbl ? 2 * u : u;
  endfunction : units

  // Start, then leave the run bit alone until the ladder switches off
  task run_conv(input logic [7:0] ctl, input int u, input logic [11:0] trial);
    int n;
    apb(1'b1, `IDX_CONTROL, ctl | 8'h04);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
      if (n == 1) begin
        check({20'h0, ladder_code}, {20'h0, trial}, "first trial");
      end
    end while (ladder_on === 1'b1 && n < 20000);
    check(n - 1, u * `UNIT_CYCLES, "conversion length");
    check({31'h0, done_irq}, {31'h0, ctl[0]}, "irq level");
    rd_check(`IDX_CONTROL, (ctl & 8'hF1) | 8'h02, "end state");
  endtask : run_conv

  task t_reset_values;
    for (int i = 0; i < 4; i++) begin
      rd_check(`IDX_CONTROL + i[15:0], 8'h00, "reset value");
    end
    apb(1'b1, 16'hFE5C, 8'hFF);
    check({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b0, 16'hFE5C, 8'h00);
    check(rd, 32'h0, "unmapped read");
    check({31'h0, err}, 32'h1, "unmapped error");
  endtask : t_reset_values

  task t_channels;
    logic [3:0] c;
    for (int i = 0; i < 3; i++) begin
      c = i[3:0];
      apb(1'b1, `IDX_CONTROL, {c, 4'h0});
      @(negedge pclk);
      check({29'h0, analog_input_sel}, 32'h1 << i, "input select");
      rd_check(`IDX_CONTROL, {c, 4'h0}, "control readback");
    end
  endtask : t_channels

  task t_first_12;
    apb(1'b1, `IDX_MODE, 8'h00);
    apb(1'b1, `IDX_RESULT_LOW, 8'h00);
    run_conv(8'h01, units(1'b0, 0, 1'b1), 12'h800);
    rd_check(`IDX_RESULT_HIGH, 8'hA5, "high byte");
    rd_check(`IDX_RESULT_LOW, 8'hC0, "low byte");
    repeat (50) @(posedge pclk);
    apb(1'b1, `IDX_CONTROL, 8'h03);
    rd_check(`IDX_CONTROL, 8'h03, "flag kept");
    apb(1'b1, `IDX_CONTROL, 8'h01);
    @(negedge pclk);
    check({31'h0, done_irq}, 32'h0, "irq after clear");
    rd_check(`IDX_CONTROL, 8'h01, "flag cleared");
    run_conv(8'h10, units(1'b0, 0, 1'b0), 12'h800);
    rd_check(`IDX_RESULT_HIGH, 8'h3C, "high byte");
    rd_check(`IDX_RESULT_LOW, 8'h70, "low byte");
    apb(1'b1, `IDX_CONTROL, 8'h00);
  endtask : t_first_12

  task t_eight_bit;
    apb(1'b1, `IDX_MODE, 8'h41);
    run_conv(8'h20, units(1'b1, 1, 1'b0), 12'h080);
    rd_check(`IDX_RESULT_HIGH, 8'hB4, "8-bit high");
    rd_check(`IDX_RESULT_LOW, 8'h70, "8-bit low kept");
    apb(1'b1, `IDX_CONTROL, 8'h00);
    apb(1'b1, `IDX_RESULT_LOW, 8'h01);
    apb(1'b1, `IDX_MODE, 8'h40);
    run_conv(8'h00, units(1'b1, 4, 1'b0), 12'h080);
    rd_check(`IDX_RESULT_HIGH, 8'hFF, "8-bit high");
    rd_check(`IDX_RESULT_LOW, 8'h01, "8-bit low kept");
    apb(1'b1, `IDX_CONTROL, 8'h00);
    apb(1'b1, `IDX_MODE, 8'h00);
    apb(1'b1, `IDX_RESULT_LOW, 8'h00);
    run_conv(8'h20, units(1'b0, 0, 1'b1), 12'h800);
    rd_check(`IDX_RESULT_HIGH, 8'h0B, "high byte");
    rd_check(`IDX_RESULT_LOW, 8'h40, "low byte");
    apb(1'b1, `IDX_CONTROL, 8'h00);
  endtask : t_eight_bit

  task t_abort;
    apb(1'b1, `IDX_CONTROL, 8'h14);
    repeat (100) @(posedge pclk);
    apb(1'b1, `IDX_CONTROL, 8'h10);
    repeat (2) @(negedge pclk);
    check({31'h0, ladder_on}, 32'h0, "ladder after abort");
    repeat (600) @(posedge pclk);
    rd_check(`IDX_CONTROL, 8'h10, "no end after abort");
    rd_check(`IDX_RESULT_HIGH, 8'h0B, "results kept");
    rd_check(`IDX_RESULT_LOW, 8'h40, "results kept");
  endtask : t_abort

  task t_reset_mid;
    apb(1'b1, `IDX_CONTROL, 8'h15);
    repeat (50) @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({31'h0, ladder_on}, 32'h0, "ladder after reset");
    rd_check(`IDX_CONTROL, 8'h00, "run after reset");
    run_conv(8'h00, units(1'b0, 0, 1'b1), 12'h800);
  endtask : t_reset_mid

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_channels();
    t_first_12();
    t_eight_bit();
    t_abort();
    t_reset_mid();
    test_done();
  end
endmodule : test_sar_adc_control_unit
